// ===== pfsa_map.svh
// Purpose: Offsets, field positions, reset values and timing counts for flash self-access
// Assumes: Core clock 200 MHz, 5 ns period
// Notes:   Included by the unlock, timer and core files and by the testbench
`ifndef PFSA_MAP_SVH
`define PFSA_MAP_SVH

// ----------------------------------------
// Special-register select codes
// ----------------------------------------
`define PFSA_SEL_CTRL      3'h0
`define PFSA_SEL_KEY       3'h1
`define PFSA_SEL_LATCH     3'h2
`define PFSA_SEL_PTR_LO    3'h3
`define PFSA_SEL_PTR_MID   3'h4
`define PFSA_SEL_PTR_UP    3'h5
`define PFSA_SEL_FLAG2     3'h6

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define PFSA_CTL_MEM       7
`define PFSA_CTL_CFG       6
`define PFSA_CTL_ERASE     4
`define PFSA_CTL_ERR       3
`define PFSA_CTL_PERMIT    2
`define PFSA_CTL_WSTART    1
`define PFSA_CTL_RSTART    0
`define PFSA_FLAG2_DONE    4
`define PFSA_CTL_RESET     8'h00

// ----------------------------------------
// Unlock keys and sizes
// ----------------------------------------
`define PFSA_KEY_FIRST     8'h55
`define PFSA_KEY_SECOND    8'hAA
`define PFSA_PTR_W         22
`define PFSA_WBLK_BYTES    8
`define PFSA_EBLK_BYTES    64

// ----------------------------------------
// Timing
// ----------------------------------------
`define PFSA_CLK_MHZ       200
`define PFSA_PROG_US       2000
`define PFSA_PROG_CYC      (`PFSA_PROG_US * `PFSA_CLK_MHZ)

`endif

// ===== pfsa_pkg.sv
// Purpose: Types for flash self-access
// Assumes: Offsets and counts come from pfsa_map.svh
// Notes:   Nothing is imported; users write pfsa_pkg::name
package pfsa_pkg;

	typedef enum logic [1:0] {
		PFSA_KEY_IDLE  = 2'b00,
		PFSA_KEY_HALF  = 2'b01,
		PFSA_KEY_OPEN  = 2'b10
	} pfsa_key_type;

	typedef enum logic [1:0] {
		PFSA_ST_IDLE   = 2'b00,
		PFSA_ST_WRITE  = 2'b01,
		PFSA_ST_ERASE  = 2'b10,
		PFSA_ST_EEWR   = 2'b11
	} pfsa_state_type;

	// Special-register access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] sel;
		logic [7:0] wdata;
	} pfsa_sfr_req_type;

	// Table operation from the core
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [1:0] mode;
	} pfsa_tbl_req_type;

	// Flash array command
	typedef struct packed {
		logic        rd;
		logic        prog;
		logic        erase;
		logic [21:0] addr;
	} pfsa_flash_cmd_type;

	localparam logic [1:0] PFSA_TM_KEEP    = 2'b00;
	localparam logic [1:0] PFSA_TM_POSTINC = 2'b01;
	localparam logic [1:0] PFSA_TM_POSTDEC = 2'b10;
	localparam logic [1:0] PFSA_TM_PREINC  = 2'b11;

endpackage

// ===== pfsa_unlock.sv
// Purpose: Unlock key port sequence tracker
// Assumes: Core writes keys as single-cycle strobes
// Notes:   No storage of key values; reads of the port give zero
`timescale 1ns/100ps
`include "pfsa_map.svh"
module pfsa_unlock (
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       nrst_in,
	// Key writes
	input  wire logic       key_wr_in,
	input  wire logic [7:0] key_data_in,
	input  wire logic       other_wr_in,
	input  wire logic       consume_in,
	// Status
	output logic            unlocked_out
);

	pfsa_pkg::pfsa_key_type key_reg;
	pfsa_pkg::pfsa_key_type key_next;

	// ----------------------------------------
	// Key sequence
	// ----------------------------------------
	// Expect 55h then AAh
	always_comb begin
		key_next = key_reg;
		if (consume_in) begin
			key_next = pfsa_pkg::PFSA_KEY_IDLE;
		end else if (key_wr_in) begin
			if (key_data_in == `PFSA_KEY_FIRST) begin
				key_next = pfsa_pkg::PFSA_KEY_HALF;
			end else if (key_data_in == `PFSA_KEY_SECOND && key_reg == pfsa_pkg::PFSA_KEY_HALF) begin
				key_next = pfsa_pkg::PFSA_KEY_OPEN;
			end else begin
				key_next = pfsa_pkg::PFSA_KEY_IDLE;
			end
		end else if (other_wr_in && key_reg == pfsa_pkg::PFSA_KEY_HALF) begin
			key_next = pfsa_pkg::PFSA_KEY_IDLE;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			key_reg <= pfsa_pkg::PFSA_KEY_IDLE;
		end else begin
			key_reg <= key_next;
		end
	end

	assign unlocked_out = (key_reg == pfsa_pkg::PFSA_KEY_OPEN);

endmodule

// ===== pfsa_timer.sv
// Purpose: Internal programming timer
// Assumes: Start is a single-cycle pulse while idle
// Notes:   Done pulses once when the count expires
`timescale 1ns/100ps
`include "pfsa_map.svh"
module pfsa_timer #(
	parameter int CYCLES = `PFSA_PROG_CYC
) (
	// Clock and reset
	input  wire logic sys_clk_in,
	input  wire logic nrst_in,
	// Control
	input  wire logic start_in,
	output logic      busy_out,
	output logic      done_out
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_reg;
	logic          run_reg;
	logic          done_reg;
	wire           expire = run_reg && (cnt_reg == LAST);

	// ----------------------------------------
	// Self-timed count
	// ----------------------------------------
	// Timer ends the operation
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			cnt_reg  <= '0;
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= expire;
			if (start_in && !run_reg) begin
				run_reg <= 1'b1;
				cnt_reg <= '0;
			end else if (expire) begin
				run_reg <= 1'b0;
			end else if (run_reg) begin
				cnt_reg <= cnt_reg + CW'(1);
			end
		end
	end

	assign busy_out = run_reg;
	assign done_out = done_reg;

endmodule

// ===== pfsa_core.sv
// Purpose: Program flash self-access controller with table latch and control register
// Assumes: Core drives special-register and table requests synchronous to sys_clk_in
// Notes:   Array timing is owned by the internal programming timer
//
// Contract
// - Write in 8-byte blocks, erase 64-byte blocks, read one byte.
// - No whole-memory erase from user code; block erases only.
// - Stall instruction fetch while a write or erase runs; code stalls only for flash targets, not data EEPROM writes.
// - Internal programming timer ends every write and erase.
// - Any value is storable; invalid fetched words run as no-operation.
// - Data moves only through the 8-bit table latch, a byte each.
// - Table writes fill holding registers; array changes only on timed write.
// - Table operations use any byte address, no word alignment.
// - Unlock key port has no storage and reads as zero.
// - Control bit 7 one selects program flash, zero data EEPROM.
// - Control bit 6 one selects configuration space regardless of bit 7.
// - Row-erase bit 4 makes next start erase; completion clears it.
// - Write-permit bit 2 clear at power-up; writes need it set.
// - Error bit 3 set on aborted or improper write, clear on completion; reset clears it here, so a reset-aborted write leaves it 0.
// - Aborted write leaves both select bits unchanged; reset here clears bits 7 and 6 with the whole control register.
// - Write-start bit 1 set-only by software, cleared by hardware on completion.
// - Completion sets done flag bit 4 of flag register 2; software clears.
// - Read-start bit 0 set-only, one-cycle EEPROM read, refused if selects set.
// - Table pointer is 22 bits; top bit reaches configuration space.
// - Erase uses pointer bits 21 to 6 and ignores 5 to 0.
// - Timed write uses pointer bits 21 to 3 for the block.
`timescale 1ns/100ps
`include "pfsa_map.svh"
module pfsa_core #(
	parameter int PROG_CYCLES = `PFSA_PROG_CYC,
	parameter int HOLD_BYTES  = `PFSA_WBLK_BYTES
) (
	// Clock and reset
	input  wire logic                       sys_clk_in,
	input  wire logic                       nrst_in,
	// Core special-register and table access
	input  wire pfsa_pkg::pfsa_sfr_req_type sfr_req_in,
	input  wire pfsa_pkg::pfsa_tbl_req_type tbl_req_in,
	output logic [7:0]                      sfr_rdata_out,
	output logic                            fetch_stall_out,
	output logic                            ee_rd_strobe_out,
	// Flash array
	output pfsa_pkg::pfsa_flash_cmd_type    flash_cmd_out,
	output logic [63:0]                     flash_wdata_out,
	input  wire logic [7:0]                 flash_rdata_in
);

	localparam int HW = $clog2(HOLD_BYTES);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]              ctrl_reg;
	logic [7:0]              latch_reg;
	logic [21:0]             ptr_reg;
	logic                    done_flag_reg;
	logic [7:0]              hold_reg [HOLD_BYTES];
	pfsa_pkg::pfsa_state_type st_reg;
	pfsa_pkg::pfsa_state_type st_next;
	logic [7:0]              rdata_reg;
	logic                    stall_reg;
	logic                    eerd_reg;
	pfsa_pkg::pfsa_flash_cmd_type cmd_reg;
	logic                    rd_pend_reg;
	logic                    err_arm_reg;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic hit(input pfsa_pkg::pfsa_sfr_req_type r, input logic [2:0] s);
		hit = r.wr && (r.sel == s);
	endfunction

	wire       wr_ctrl   = hit(sfr_req_in, `PFSA_SEL_CTRL);
	wire       wr_key    = hit(sfr_req_in, `PFSA_SEL_KEY);
	wire       wr_latch  = hit(sfr_req_in, `PFSA_SEL_LATCH);
	wire       wr_flag2  = hit(sfr_req_in, `PFSA_SEL_FLAG2);
	wire [7:0] wd        = sfr_req_in.wdata;
	wire       idle      = (st_reg == pfsa_pkg::PFSA_ST_IDLE);
	wire       unlocked;
	wire       tmr_busy;
	wire       tmr_done;
	wire       erase_sel = ctrl_reg[`PFSA_CTL_ERASE];
	wire       cfg_sel   = ctrl_reg[`PFSA_CTL_CFG];
	wire       mem_sel   = ctrl_reg[`PFSA_CTL_MEM];
	wire       permit    = ctrl_reg[`PFSA_CTL_PERMIT];
	wire       start_req = wr_ctrl && wd[`PFSA_CTL_WSTART] && !ctrl_reg[`PFSA_CTL_WSTART] && idle;
	wire       start_ok  = start_req && permit && unlocked;
	wire       start_bad = start_req && !(permit && unlocked);
	wire       rd_ok     = wr_ctrl && wd[`PFSA_CTL_RSTART] && !wd[`PFSA_CTL_MEM] && !wd[`PFSA_CTL_CFG] && idle;
	wire       flash_tgt = mem_sel || cfg_sel;
	wire       tbl_busy  = !idle;
	// 22-bit pointer, step on low 21
	wire [20:0] ptr_inc  = ptr_reg[20:0] + 21'h000001;
	wire [20:0] ptr_dec  = ptr_reg[20:0] - 21'h000001;
	wire [21:0] ptr_eff  = (tbl_req_in.mode == pfsa_pkg::PFSA_TM_PREINC) ? {ptr_reg[21], ptr_inc} : ptr_reg;

	pfsa_unlock u_unlock (
		.sys_clk_in   (sys_clk_in),
		.nrst_in      (nrst_in),
		.key_wr_in    (wr_key),
		.key_data_in  (wd),
		.other_wr_in  (sfr_req_in.wr && !wr_key && !start_req),
		.consume_in   (start_req),
		.unlocked_out (unlocked)
	);

	pfsa_timer #(
		.CYCLES (PROG_CYCLES)
	) u_timer (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.start_in   (start_ok),
		.busy_out   (tmr_busy),
		.done_out   (tmr_done)
	);

	// ----------------------------------------
	// Operation state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			pfsa_pkg::PFSA_ST_IDLE: begin
				if (start_ok) begin
					if (!flash_tgt) begin
						st_next = pfsa_pkg::PFSA_ST_EEWR;
					end else if (erase_sel) begin
						st_next = pfsa_pkg::PFSA_ST_ERASE;
					end else begin
						st_next = pfsa_pkg::PFSA_ST_WRITE;
					end
				end
			end
			pfsa_pkg::PFSA_ST_WRITE,
			pfsa_pkg::PFSA_ST_ERASE,
			pfsa_pkg::PFSA_ST_EEWR: begin
				if (tmr_done) begin
					st_next = pfsa_pkg::PFSA_ST_IDLE;
				end
			end
			default: st_next = pfsa_pkg::PFSA_ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			ctrl_reg    <= `PFSA_CTL_RESET;
			err_arm_reg <= 1'b0;
			st_reg      <= pfsa_pkg::PFSA_ST_IDLE;
		end else begin
			st_reg <= st_next;
			if (wr_ctrl) begin
				ctrl_reg[`PFSA_CTL_MEM]    <= wd[`PFSA_CTL_MEM];
				ctrl_reg[`PFSA_CTL_CFG]    <= wd[`PFSA_CTL_CFG];
				ctrl_reg[`PFSA_CTL_ERASE]  <= wd[`PFSA_CTL_ERASE];
				ctrl_reg[`PFSA_CTL_PERMIT] <= wd[`PFSA_CTL_PERMIT];
				ctrl_reg[`PFSA_CTL_ERR]    <= wd[`PFSA_CTL_ERR];
			end
			if (start_ok) begin
				ctrl_reg[`PFSA_CTL_WSTART] <= 1'b1;
				ctrl_reg[`PFSA_CTL_ERR]    <= 1'b1;
				err_arm_reg                <= 1'b1;
			end else if (tmr_done) begin
				ctrl_reg[`PFSA_CTL_WSTART] <= 1'b0;
				ctrl_reg[`PFSA_CTL_ERR]    <= 1'b0;
				err_arm_reg                <= 1'b0;
				if (st_reg == pfsa_pkg::PFSA_ST_ERASE) begin
					ctrl_reg[`PFSA_CTL_ERASE] <= 1'b0;
				end
			end
			if (start_bad) begin
				ctrl_reg[`PFSA_CTL_ERR] <= 1'b1;
			end
			ctrl_reg[`PFSA_CTL_RSTART] <= rd_ok;
			ctrl_reg[5] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Table pointer, latch, holding registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			ptr_reg     <= '0;
			latch_reg   <= 8'h00;
			rd_pend_reg <= 1'b0;
		end else begin
			rd_pend_reg <= tbl_req_in.rd && !tbl_busy;
			if (hit(sfr_req_in, `PFSA_SEL_PTR_LO)) ptr_reg[7:0] <= wd;
			if (hit(sfr_req_in, `PFSA_SEL_PTR_MID)) ptr_reg[15:8] <= wd;
			if (hit(sfr_req_in, `PFSA_SEL_PTR_UP)) ptr_reg[21:16] <= wd[5:0];
			if (wr_latch) begin
				latch_reg <= wd;
			end else if (rd_pend_reg) begin
				latch_reg <= flash_rdata_in;
			end
			if ((tbl_req_in.rd || tbl_req_in.wr) && !tbl_busy) begin
				case (tbl_req_in.mode)
					pfsa_pkg::PFSA_TM_POSTINC,
					pfsa_pkg::PFSA_TM_PREINC: ptr_reg[20:0] <= ptr_inc;
					pfsa_pkg::PFSA_TM_POSTDEC: ptr_reg[20:0] <= ptr_dec;
					default: ptr_reg[20:0] <= ptr_reg[20:0];
				endcase
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < HOLD_BYTES; gi++) begin : g_hold
			always_ff @(posedge sys_clk_in) begin
				if (!nrst_in) begin
					hold_reg[gi] <= 8'hFF;
				end else if (tbl_req_in.wr && !tbl_busy && ptr_eff[HW-1:0] == HW'(gi)) begin
					hold_reg[gi] <= latch_reg;
				end
			end
			assign flash_wdata_out[gi*8 +: 8] = hold_reg[gi];
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			rdata_reg     <= 8'h00;
			stall_reg     <= 1'b0;
			eerd_reg      <= 1'b0;
			cmd_reg       <= '0;
			done_flag_reg <= 1'b0;
		end else begin
			case (sfr_req_in.sel)
				`PFSA_SEL_CTRL:    rdata_reg <= ctrl_reg;
				`PFSA_SEL_LATCH:   rdata_reg <= latch_reg;
				`PFSA_SEL_PTR_LO:  rdata_reg <= ptr_reg[7:0];
				`PFSA_SEL_PTR_MID: rdata_reg <= ptr_reg[15:8];
				`PFSA_SEL_PTR_UP:  rdata_reg <= {2'b00, ptr_reg[21:16]};
				`PFSA_SEL_FLAG2:   rdata_reg <= {3'b000, done_flag_reg, 4'h0};
				default:           rdata_reg <= 8'h00;
			endcase
			stall_reg <= (st_next == pfsa_pkg::PFSA_ST_WRITE) || (st_next == pfsa_pkg::PFSA_ST_ERASE);
			eerd_reg  <= rd_ok;
			if (tmr_done) begin
				done_flag_reg <= 1'b1;
			end else if (wr_flag2) begin
				done_flag_reg <= wd[`PFSA_FLAG2_DONE];
			end
			cmd_reg.rd <= tbl_req_in.rd && !tbl_busy;
			// Erase never wider than a row
			cmd_reg.prog  <= tmr_done && (st_reg == pfsa_pkg::PFSA_ST_WRITE);
			cmd_reg.erase <= tmr_done && (st_reg == pfsa_pkg::PFSA_ST_ERASE);
			if (tbl_req_in.rd && !tbl_busy) begin
				cmd_reg.addr <= ptr_eff;
			end else if (st_reg == pfsa_pkg::PFSA_ST_ERASE) begin
				// Row from bits 21 to 6
				cmd_reg.addr <= {ptr_reg[21:6], 6'h00};
			end else if (st_reg == pfsa_pkg::PFSA_ST_WRITE) begin
				// Block from bits 21 to 3
				cmd_reg.addr <= {ptr_reg[21:3], 3'h0};
			end
		end
	end

	assign sfr_rdata_out    = rdata_reg;
	assign fetch_stall_out  = stall_reg;
	assign ee_rd_strobe_out = eerd_reg;
	assign flash_cmd_out    = cmd_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence start_seq;
		start_ok;
	endsequence

	stall_on_start_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		start_ok && flash_tgt |=> fetch_stall_out) else $error("fetch not stalled");
	timer_ends_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		tmr_done |=> idle && !ctrl_reg[`PFSA_CTL_WSTART]) else $error("op not ended");
	permit_gate_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		start_req && !permit |=> idle) else $error("write without permit");
	bad_start_err_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		start_bad |=> ctrl_reg[`PFSA_CTL_ERR] && !flash_cmd_out.prog) else $error("bad start missed");
	read_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		ctrl_reg[`PFSA_CTL_RSTART] |=> !ctrl_reg[`PFSA_CTL_RSTART]) else $error("read bit stuck");
	done_flag_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		tmr_done |=> done_flag_reg) else $error("done flag missing");
	key_zero_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		sfr_req_in.sel == `PFSA_SEL_KEY |=> sfr_rdata_out == 8'h00) else $error("key port nonzero");
	start_held_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		start_seq |=> ctrl_reg[`PFSA_CTL_WSTART] [*2]) else $error("start bit dropped");
	erase_align_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		flash_cmd_out.erase |-> flash_cmd_out.addr[5:0] == 6'h00) else $error("erase misaligned");

endmodule

// ===== pfsa_flash_model.sv
// Purpose: Behavioural program flash array beside the controller
// Assumes: Commands are single-cycle pulses; reads answer combinationally
// Notes:   Only the low 1 KiB of the array is stored
`timescale 1ns/100ps
module pfsa_flash_model (
	// Clock
	input  wire logic                          sys_clk_in,
	// Command side
	input  wire pfsa_pkg::pfsa_flash_cmd_type  cmd_in,
	input  wire logic [63:0]                   wdata_in,
	// Read data
	output logic [7:0]                         rdata_out
);
	logic [7:0] mem [0:1023];
	logic [7:0] last_q;
	int         b;

	initial begin
		for (b = 0; b < 1024; b++) begin
			mem[b] = b[7:0] ^ 8'h3C;
		end
		last_q = 8'h00;
	end

	always @(posedge sys_clk_in) begin
		if (cmd_in.prog) begin
			for (b = 0; b < 8; b++) begin
				mem[{cmd_in.addr[9:3], b[2:0]}] <= wdata_in[8*b +: 8];
			end
		end
		if (cmd_in.erase) begin
			for (b = 0; b < 64; b++) begin
				mem[{cmd_in.addr[9:6], b[5:0]}] <= 8'hFF;
			end
		end
		if (cmd_in.rd) begin
			last_q <= rdata_out;
		end
	end

	// Idle bus shows inverse of last byte
	assign rdata_out = cmd_in.rd ? mem[cmd_in.addr[9:0]] : ~last_q;
endmodule

// ===== test_program_flash_self_access.sv
// Purpose: Self-checking bench for flash self-access controller
// Assumes: Timer shortened to 10 cycles
// Notes:   Array model answers table reads
`timescale 1ns/100ps
`include "pfsa_map.svh"
module test_program_flash_self_access;
	logic                         sys_clk_in = 1'b0;
	logic                         nrst_in;
	pfsa_pkg::pfsa_sfr_req_type   sfr;
	pfsa_pkg::pfsa_tbl_req_type   tbl;
	logic [7:0]                   rdata;
	logic                         stall;
	logic                         ee_rd;
	pfsa_pkg::pfsa_flash_cmd_type cmd;
	pfsa_pkg::pfsa_flash_cmd_type cmd_seen;
	logic [63:0]                  fwd;
	logic [7:0]                   frd;
	logic [7:0]                   v;
	int                           bad_count = 0;
	int                           compares = 0;
	int                           cyc = 0;
	int                           n_ee = 0;
	int                           n_op = 0;
	int                           n0;

	always #2.5 sys_clk_in = ~sys_clk_in;

	pfsa_core #(.PROG_CYCLES(10), .HOLD_BYTES(8)) dut (
		.sys_clk_in      (sys_clk_in),
		.nrst_in         (nrst_in),
		.sfr_req_in      (sfr),
		.tbl_req_in      (tbl),
		.sfr_rdata_out   (rdata),
		.fetch_stall_out (stall),
		.ee_rd_strobe_out(ee_rd),
		.flash_cmd_out   (cmd),
		.flash_wdata_out (fwd),
		.flash_rdata_in  (frd)
	);

	pfsa_flash_model array_model (
		.sys_clk_in(sys_clk_in),
		.cmd_in    (cmd),
		.wdata_in  (fwd),
		.rdata_out (frd)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk_in) begin
		cyc++;
		if (ee_rd === 1'b1) n_ee++;
		if (cmd.prog === 1'b1 || cmd.erase === 1'b1) n_op++;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [2:0] s, input logic [7:0] d);
		@(posedge sys_clk_in);
		sfr <= '{1'b1, 1'b0, s, d};
	endtask

	task automatic rreg(input logic [2:0] s);
		@(posedge sys_clk_in);
		sfr <= '{1'b0, 1'b1, s, 8'h00};
		@(posedge sys_clk_in);
		#1 v = rdata;
	endtask

	task automatic top(input logic r, input logic w, input logic [1:0] m);
		@(posedge sys_clk_in);
		sfr <= '0;
		tbl <= '{r, w, m};
		@(posedge sys_clk_in);
		tbl <= '0;
		#1 cmd_seen = cmd;
	endtask

	task automatic rd_chk(input logic [1:0] m, input logic [21:0] a, input logic [7:0] e);
		top(1'b1, 1'b0, m);
		chk(cmd_seen.addr, a);
		rreg(`PFSA_SEL_LATCH);
		chk(v, e);
	endtask

	task automatic setptr(input logic [21:0] p);
		wreg(`PFSA_SEL_PTR_LO, p[7:0]);
		wreg(`PFSA_SEL_PTR_MID, p[15:8]);
		wreg(`PFSA_SEL_PTR_UP, {2'b00, p[21:16]});
	endtask

	task automatic unlock;
		wreg(`PFSA_SEL_KEY, `PFSA_KEY_FIRST);
		wreg(`PFSA_SEL_KEY, `PFSA_KEY_SECOND);
	endtask

	task automatic wait_end;
		int n;
		for (n = 0; n < 60; n++) begin
			@(posedge sys_clk_in);
			sfr <= '0;
			#1 cmd_seen = cmd;
			if (cmd_seen.prog === 1'b1 || cmd_seen.erase === 1'b1) break;
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h00);
		wreg(`PFSA_SEL_KEY, `PFSA_KEY_FIRST);
		rreg(`PFSA_SEL_KEY);
		chk(v, 8'h00);
	endtask

	task automatic t_read;
		setptr(22'h000005);
		rd_chk(pfsa_pkg::PFSA_TM_POSTINC, 22'h05, 8'h39);
		rd_chk(pfsa_pkg::PFSA_TM_PREINC, 22'h07, 8'h3B);
		rd_chk(pfsa_pkg::PFSA_TM_POSTDEC, 22'h07, 8'h3B);
		rd_chk(pfsa_pkg::PFSA_TM_KEEP, 22'h06, 8'h3A);
	endtask

	task automatic t_write;
		int i;
		setptr(22'h000010);
		n0 = n_op;
		for (i = 0; i < 8; i++) begin
			wreg(`PFSA_SEL_LATCH, 8'hA0 + i[7:0]);
			top(1'b0, 1'b1, (i == 7) ? pfsa_pkg::PFSA_TM_KEEP : pfsa_pkg::PFSA_TM_POSTINC);
		end
		chk(fwd, 64'hA7A6A5A4A3A2A1A0);
		chk(n_op - n0, 0);
		wreg(`PFSA_SEL_CTRL, 8'h84);
		unlock();
		wreg(`PFSA_SEL_CTRL, 8'h86);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h8E);
		chk(stall, 1'b1);
		wreg(`PFSA_SEL_CTRL, 8'h8C);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h8E);
		wait_end();
		chk(cmd_seen.prog, 1'b1);
		chk(cmd_seen.addr, 22'h10);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h84);
		chk(stall, 1'b0);
		rreg(`PFSA_SEL_FLAG2);
		chk(v[4], 1'b1);
		wreg(`PFSA_SEL_FLAG2, 8'h00);
		rreg(`PFSA_SEL_FLAG2);
		chk(v[4], 1'b0);
		setptr(22'h000013);
		rd_chk(pfsa_pkg::PFSA_TM_KEEP, 22'h13, 8'hA3);
	endtask

	task automatic t_erase;
		setptr(22'h000047);
		wreg(`PFSA_SEL_CTRL, 8'h94);
		unlock();
		wreg(`PFSA_SEL_CTRL, 8'h96);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h9E);
		wait_end();
		chk(cmd_seen.erase, 1'b1);
		chk(cmd_seen.addr, 22'h40);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h84);
		setptr(22'h00003F);
		rd_chk(pfsa_pkg::PFSA_TM_POSTINC, 22'h3F, 8'h03);
		rd_chk(pfsa_pkg::PFSA_TM_KEEP, 22'h40, 8'hFF);
		setptr(22'h00007F);
		rd_chk(pfsa_pkg::PFSA_TM_POSTINC, 22'h7F, 8'hFF);
		rd_chk(pfsa_pkg::PFSA_TM_KEEP, 22'h80, 8'hBC);
	endtask

	task automatic t_refuse;
		n0 = n_op;
		wreg(`PFSA_SEL_CTRL, 8'h86);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h8C);
		chk(stall, 1'b0);
		wreg(`PFSA_SEL_CTRL, 8'hC0);
		unlock();
		wreg(`PFSA_SEL_CTRL, 8'hC2);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'hC8);
		repeat (15) @(posedge sys_clk_in);
		chk(n_op - n0, 0);
	endtask

	task automatic t_ee_read;
		wreg(`PFSA_SEL_CTRL, 8'h00);
		n0 = n_ee;
		wreg(`PFSA_SEL_CTRL, 8'h01);
		rreg(`PFSA_SEL_CTRL);
		rreg(`PFSA_SEL_CTRL);
		chk(n_ee - n0, 1);
		chk(v[0], 1'b0);
		wreg(`PFSA_SEL_CTRL, 8'h81);
		rreg(`PFSA_SEL_CTRL);
		rreg(`PFSA_SEL_CTRL);
		chk(n_ee - n0, 1);
		chk(v, 8'h80);
		wreg(`PFSA_SEL_CTRL, 8'h04);
		n0 = n_op;
		unlock();
		wreg(`PFSA_SEL_CTRL, 8'h06);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h0E);
		chk(stall, 1'b0);
		repeat (15) @(posedge sys_clk_in);
		chk(n_op - n0, 0);
		rreg(`PFSA_SEL_CTRL);
		chk(v, 8'h04);
	endtask

	initial begin
		nrst_in = 1'b0;
		sfr = '0;
		tbl = '0;
		repeat (5) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_read();
		t_write();
		t_erase();
		t_refuse();
		t_ee_read();
		final_report();
	end
endmodule
